// [core/pax_port.sv]
// Port A pin logic, pin output priorities and alternate pin select
//
// Operation
// - Six pins, each with direction and readable value; all but pin 3 bidirectional with a latch.
// - Direction one disables driver; zero drives pin from latch.
// - Pin 3 is input only; its direction bit always reads one.
// - Port data reads give pin levels; writes go to the latch.
// - Port data writes sample pins, merge the write, store in latch.
// - Direction bits still gate drivers on pins used as analog inputs.
// - Threshold select picks Schmitt or TTL level for digital reads.
// - Each pin has a weak pull-up enabled by a six-bit field.
// - Pull-up is off while its pin is an output.
// - Global pull-up disable resets to the disabling state.
// - Analog-selected pins read zero digitally and enable analog input.
// - Analog select does not stop digital output drive.
// - Lowest-numbered enabled source drives the pin, analog mode included.
// - Pins 0 to 2 use the fixed three-source priority orders.
// - Pin 4 uses its five-source order; pin 3 has no output source.
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pax_port
  import pax_pkg::*;
#(
  parameter int P5_EXTRA = 2,
  parameter bit P5_CCP_FIRST = 1'b0
) (
  input wire logic core_clk,
  input wire logic nrst,
  // AXI4-Lite slave
  input wire logic [PAX_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [PAX_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins: level seen through each input buffer
  input wire logic [PAX_NPINS-1:0] pin_st_i,
  input wire logic [PAX_NPINS-1:0] pin_ttl_i,
  output logic [PAX_NPINS-1:0] pin_o,
  output logic [PAX_NPINS-1:0] pin_oe,
  output logic [PAX_NPINS-1:0] pin_pullup_on,
  output logic [PAX_NPINS-1:0] pin_analog_en,
  output logic [PAX_NPINS-1:0] pin_din,
  // Peripheral outputs, pin 0
  input wire logic prog_data_en,
  input wire logic prog_data_val,
  input wire logic debug_data_en,
  input wire logic debug_data_val,
  input wire logic dac_output_en,
  input wire logic dac_output_val,
  // Pin 1
  input wire logic prog_clock_en,
  input wire logic prog_clock_val,
  input wire logic debug_clock_en,
  input wire logic debug_clock_val,
  input wire logic serial_rx_data_en,
  input wire logic serial_rx_data_val,
  // Pin 2
  input wire logic sr_latch_out_en,
  input wire logic sr_latch_out_val,
  input wire logic comparator_one_out_en,
  input wire logic comparator_one_out_val,
  input wire logic capture_compare_three_en,
  input wire logic capture_compare_three_val,
  // Pin 4
  input wire logic clock_output_en,
  input wire logic clock_output_val,
  input wire logic timer_one_osc_out_en,
  input wire logic timer_one_osc_out_val,
  input wire logic reference_clock_out_en,
  input wire logic reference_clock_out_val,
  input wire logic spi_sdo_en,
  input wire logic spi_sdo_val,
  // Routed sources
  input wire logic pwm2_b_out_en,
  input wire logic pwm2_b_out_val,
  input wire logic pwm1_d_out_en,
  input wire logic pwm1_d_out_val,
  input wire logic pwm1_c_out_en,
  input wire logic pwm1_c_out_val,
  input wire logic ccp_two_primary_out_en,
  input wire logic ccp_two_primary_out_val,
  // Pin 5 other sources, index 0 highest
  input wire logic [P5_EXTRA-1:0] pin5_src_en,
  input wire logic [P5_EXTRA-1:0] pin5_src_val,
  // Overrides toward port C pins 0..3 and the CCP2 default pin
  output logic [3:0] portc_ovr_en,
  output logic [3:0] portc_ovr_val,
  output logic ccp_two_dflt_en,
  output logic ccp_two_dflt_val
);
  // Configuration registers
  logic [5:0] dir_bits_r;
  logic [5:0] out_latch_r;
  logic [5:0] analog_select_r;
  logic [5:0] input_threshold_sel_r;
  logic [5:0] pullup_enable_r;
  logic global_pullup_disable_r;
  logic [7:0] alt_pin_select_1_r;
  logic [5:0] pin_level_r;
  logic [5:0] port_data_rd;
  logic [5:0] dir_eff;

  // Route selects
  logic pwm1_d_route_sel;
  logic pwm1_c_route_sel;
  logic pwm2_b_route_sel;
  logic ccp_two_route_sel;

  // Write channel
  pax_ch_state_t wr_st_r;
  logic aw_held_r;
  logic w_held_r;
  logic [PAX_AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;
  logic wr_hit;
  pax_ch_state_t rd_st_r;

  assign pwm1_d_route_sel = alt_pin_select_1_r[PAX_ALT1_PWM1_D_BIT];
  assign pwm1_c_route_sel = alt_pin_select_1_r[PAX_ALT1_PWM1_C_BIT];
  assign pwm2_b_route_sel = alt_pin_select_1_r[PAX_ALT1_PWM2_B_BIT];
  assign ccp_two_route_sel = alt_pin_select_1_r[PAX_ALT1_CCP2_BIT];

  // Pin 3 can never drive
  assign dir_eff = dir_bits_r | PAX_DIR_FORCED_ONE;

  // Pin sampling through the chosen threshold buffer
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pin_level_r <= 6'h00;
    end else begin
      for (int i = 0; i < PAX_NPINS; i++) begin
        pin_level_r[i] <= input_threshold_sel_r[i] ? pin_ttl_i[i] : pin_st_i[i];
      end
    end
  end

  // Analog pins read zero
  assign port_data_rd = pin_level_r & ~analog_select_r;

  // Write address and data taken independently, in either order
  assign wr_fire = aw_held_r && w_held_r && (wr_st_r == PAX_CH_IDLE);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      w_held_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready)
        && (wr_st_r == PAX_CH_IDLE);
      s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready)
        && (wr_st_r == PAX_CH_IDLE);
    end
  end

  always_comb begin
    unique case (awaddr_r)
      PAX_OFS_PORT_DATA,
      PAX_OFS_DIR_BITS,
      PAX_OFS_OUT_LATCH,
      PAX_OFS_ANALOG_SEL,
      PAX_OFS_THRESH_SEL,
      PAX_OFS_PULLUP_EN,
      PAX_OFS_OPTION,
      PAX_OFS_ALT_PIN_SEL1: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wr_st_r <= PAX_CH_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PAX_RESP_OKAY;
    end else begin
      unique case (wr_st_r)
        PAX_CH_IDLE: begin
          if (wr_fire) begin
            wr_st_r <= PAX_CH_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? PAX_RESP_OKAY : PAX_RESP_SLVERR;
          end
        end
        PAX_CH_RESP: begin
          if (s_axi_bready) begin
            wr_st_r <= PAX_CH_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
      endcase
    end
  end

  // Register updates; byte lane 0 carries every field
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      dir_bits_r <= PAX_DIR_RST;
      analog_select_r <= PAX_ANALOG_RST;
      input_threshold_sel_r <= PAX_THRESH_RST;
      pullup_enable_r <= PAX_PULLUP_RST;
    end else if (wr_fire && wstrb_r[0]) begin
      unique case (awaddr_r)
        PAX_OFS_DIR_BITS: dir_bits_r <= wdata_r[5:0] | PAX_DIR_FORCED_ONE;
        PAX_OFS_ANALOG_SEL: analog_select_r <= wdata_r[5:0] & PAX_ANALOG_MASK;
        PAX_OFS_THRESH_SEL: input_threshold_sel_r <= wdata_r[5:0];
        PAX_OFS_PULLUP_EN: pullup_enable_r <= wdata_r[5:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      global_pullup_disable_r <= PAX_GPU_DIS_RST;
      alt_pin_select_1_r <= PAX_ALT1_RST;
    end else if (wr_fire && wstrb_r[0]) begin
      if (awaddr_r == PAX_OFS_OPTION) begin
        global_pullup_disable_r <= wdata_r[PAX_OPT_GPU_DIS_BIT];
      end
      if (awaddr_r == PAX_OFS_ALT_PIN_SEL1) begin
        alt_pin_select_1_r <= wdata_r[7:0] & PAX_ALT1_MASK;
      end
    end
  end

  // Port data writes land in the latch; lane 0 absent keeps pin readback
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      out_latch_r <= PAX_LATCH_RST;
    end else if (wr_fire && awaddr_r == PAX_OFS_PORT_DATA) begin
      out_latch_r <= (wstrb_r[0] ? wdata_r[5:0] : port_data_rd) & PAX_LATCH_MASK;
    end else if (wr_fire && wstrb_r[0] && awaddr_r == PAX_OFS_OUT_LATCH) begin
      out_latch_r <= wdata_r[5:0] & PAX_LATCH_MASK;
    end
  end

  // Read channel
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rd_st_r <= PAX_CH_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= PAX_RESP_OKAY;
    end else begin
      unique case (rd_st_r)
        PAX_CH_IDLE: begin
          s_axi_arready <= !(s_axi_arvalid && s_axi_arready);
          if (s_axi_arvalid && s_axi_arready) begin
            rd_st_r <= PAX_CH_RESP;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= PAX_RESP_OKAY;
            unique case (s_axi_araddr)
              PAX_OFS_PORT_DATA: s_axi_rdata <= {26'h0, port_data_rd};
              PAX_OFS_DIR_BITS: s_axi_rdata <= {26'h0, dir_eff};
              PAX_OFS_OUT_LATCH: s_axi_rdata <= {26'h0, out_latch_r};
              PAX_OFS_ANALOG_SEL: s_axi_rdata <= {26'h0, analog_select_r};
              PAX_OFS_THRESH_SEL: s_axi_rdata <= {26'h0, input_threshold_sel_r};
              PAX_OFS_PULLUP_EN: s_axi_rdata <= {26'h0, pullup_enable_r};
              PAX_OFS_OPTION: s_axi_rdata <= {24'h0, global_pullup_disable_r, 7'h00};
              PAX_OFS_ALT_PIN_SEL1: s_axi_rdata <= {24'h0, alt_pin_select_1_r};
              default: begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= PAX_RESP_SLVERR;
              end
            endcase
          end
        end
        PAX_CH_RESP: begin
          s_axi_arready <= 1'b0;
          if (s_axi_rready) begin
            rd_st_r <= PAX_CH_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
      endcase
    end
  end

  // Peripheral sources per pin, index 0 is highest priority
  logic [PAX_NSRC-1:0] src_en [PAX_NPINS];
  logic [PAX_NSRC-1:0] src_val [PAX_NPINS];
  logic [P5_EXTRA:0] p5_en;
  logic [P5_EXTRA:0] p5_val;
  logic p5_hit;
  logic p5_v;
  logic ccp_on_a5;

  assign ccp_on_a5 = ccp_two_primary_out_en && ccp_two_route_sel;

  always_comb begin
    if (P5_CCP_FIRST) begin
      p5_en = {pin5_src_en, ccp_on_a5};
      p5_val = {pin5_src_val, ccp_two_primary_out_val};
    end else begin
      p5_en = {ccp_on_a5, pin5_src_en};
      p5_val = {ccp_two_primary_out_val, pin5_src_val};
    end
  end

  pax_prio_mux #(.N(P5_EXTRA + 1)) u_p5_mux (
    .src_en(p5_en),
    .src_val(p5_val),
    .hit(p5_hit),
    .val(p5_v)
  );

  always_comb begin
    src_en[0] = {2'b00, dac_output_en, debug_data_en, prog_data_en};
    src_val[0] = {2'b00, dac_output_val, debug_data_val, prog_data_val};
    src_en[1] = {2'b00, serial_rx_data_en, debug_clock_en, prog_clock_en};
    src_val[1] = {2'b00, serial_rx_data_val, debug_clock_val, prog_clock_val};
    src_en[2] = {2'b00, capture_compare_three_en, comparator_one_out_en,
      sr_latch_out_en};
    src_val[2] = {2'b00, capture_compare_three_val, comparator_one_out_val,
      sr_latch_out_val};
    src_en[3] = 5'h00;
    src_val[3] = 5'h00;
    src_en[4] = {pwm2_b_out_en && pwm2_b_route_sel, spi_sdo_en, reference_clock_out_en,
      timer_one_osc_out_en, clock_output_en};
    src_val[4] = {pwm2_b_out_val, spi_sdo_val, reference_clock_out_val,
      timer_one_osc_out_val, clock_output_val};
    src_en[5] = {4'h0, p5_hit};
    src_val[5] = {4'h0, p5_v};
  end

  // Per-pin drive, pull-up and input registers
  genvar g;
  generate
    for (g = 0; g < PAX_NPINS; g++) begin : g_pin
      logic hit;
      logic val;
      pax_prio_mux #(.N(PAX_NSRC)) u_mux (
        .src_en(src_en[g]),
        .src_val(src_val[g]),
        .hit(hit),
        .val(val)
      );
      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          pin_o[g] <= 1'b0;
          pin_oe[g] <= 1'b0;
          pin_pullup_on[g] <= 1'b0;
          pin_analog_en[g] <= PAX_ANALOG_RST[g];
          pin_din[g] <= 1'b0;
        end else begin
          // Peripheral wins over latch; analog mode does not block it
          pin_o[g] <= hit ? val : out_latch_r[g];
          pin_oe[g] <= !dir_eff[g] && PAX_OUTPUT_CAPABLE[g];
          pin_pullup_on[g] <= pullup_enable_r[g] && dir_eff[g]
            && !global_pullup_disable_r;
          pin_analog_en[g] <= analog_select_r[g];
          pin_din[g] <= port_data_rd[g];
        end
      end
    end
  endgenerate

  // Port C and CCP2 default pin overrides
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      portc_ovr_en <= 4'h0;
      portc_ovr_val <= 4'h0;
      ccp_two_dflt_en <= 1'b0;
      ccp_two_dflt_val <= 1'b0;
    end else begin
      portc_ovr_en[0] <= pwm1_d_out_en && pwm1_d_route_sel;
      portc_ovr_val[0] <= pwm1_d_out_val;
      portc_ovr_en[1] <= pwm1_c_out_en && pwm1_c_route_sel;
      portc_ovr_val[1] <= pwm1_c_out_val;
      portc_ovr_en[2] <= (pwm1_d_out_en && !pwm1_d_route_sel)
        || (pwm2_b_out_en && !pwm2_b_route_sel);
      portc_ovr_val[2] <= (pwm1_d_out_en && !pwm1_d_route_sel) ? pwm1_d_out_val
        : pwm2_b_out_val;
      portc_ovr_en[3] <= pwm1_c_out_en && !pwm1_c_route_sel;
      portc_ovr_val[3] <= pwm1_c_out_val;
      ccp_two_dflt_en <= ccp_two_primary_out_en && !ccp_two_route_sel;
      ccp_two_dflt_val <= ccp_two_primary_out_val;
    end
  end
endmodule

// [core/pax_pkg.sv]
// Constants and types shared by the port A block
package pax_pkg;
  localparam int PAX_NPINS = 6;
  localparam int PAX_NSRC = 5;
  localparam int PAX_AW = 6;
  // Register byte offsets
  localparam logic [PAX_AW-1:0] PAX_OFS_PORT_DATA = 6'h00;
  localparam logic [PAX_AW-1:0] PAX_OFS_DIR_BITS = 6'h04;
  localparam logic [PAX_AW-1:0] PAX_OFS_OUT_LATCH = 6'h08;
  localparam logic [PAX_AW-1:0] PAX_OFS_ANALOG_SEL = 6'h0c;
  localparam logic [PAX_AW-1:0] PAX_OFS_THRESH_SEL = 6'h10;
  localparam logic [PAX_AW-1:0] PAX_OFS_PULLUP_EN = 6'h14;
  localparam logic [PAX_AW-1:0] PAX_OFS_OPTION = 6'h18;
  localparam logic [PAX_AW-1:0] PAX_OFS_ALT_PIN_SEL1 = 6'h1c;
  // Implemented-bit masks
  localparam logic [5:0] PAX_DIR_FORCED_ONE = 6'h08;
  localparam logic [5:0] PAX_LATCH_MASK = 6'h37;
  localparam logic [5:0] PAX_ANALOG_MASK = 6'h17;
  localparam logic [5:0] PAX_OUTPUT_CAPABLE = 6'h37;
  localparam logic [7:0] PAX_ALT1_MASK = 8'h0f;
  // Field positions
  localparam int PAX_OPT_GPU_DIS_BIT = 7;
  localparam int PAX_ALT1_PWM1_D_BIT = 3;
  localparam int PAX_ALT1_PWM1_C_BIT = 2;
  localparam int PAX_ALT1_PWM2_B_BIT = 1;
  localparam int PAX_ALT1_CCP2_BIT = 0;
  // Reset values
  localparam logic [5:0] PAX_DIR_RST = 6'h3f;
  localparam logic [5:0] PAX_LATCH_RST = 6'h00;
  localparam logic [5:0] PAX_ANALOG_RST = 6'h17;
  localparam logic [5:0] PAX_THRESH_RST = 6'h00;
  localparam logic [5:0] PAX_PULLUP_RST = 6'h00;
  localparam logic PAX_GPU_DIS_RST = 1'b1;
  localparam logic [7:0] PAX_ALT1_RST = 8'h00;
  // Bus responses
  localparam logic [1:0] PAX_RESP_OKAY = 2'h0;
  localparam logic [1:0] PAX_RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    PAX_CH_IDLE = 1'b0,
    PAX_CH_RESP = 1'b1
  } pax_ch_state_t;
endpackage

// [core/pax_prio_mux.sv]
// Fixed-priority selector: lowest enabled index drives the pin
`timescale 1ns/1ps
module pax_prio_mux #(
  parameter int N = 5
) (
  input wire logic [N-1:0] src_en,
  input wire logic [N-1:0] src_val,
  output logic hit,
  output logic val
);
  always_comb begin
    hit = 1'b0;
    val = 1'b0;
    for (int k = N - 1; k >= 0; k--) begin
      if (src_en[k]) begin
        hit = 1'b1;
        val = src_val[k];
      end
    end
  end
endmodule

// [test/pax_port_checker.sv]
// Port-level assertions for the port A block
`timescale 1ns/1ps
module pax_port_checker (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] pin_o,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] pin_pullup_on,
  input wire logic [5:0] pin_analog_en,
  input wire logic [5:0] pin_din,
  input wire logic prog_data_en,
  input wire logic prog_data_val,
  input wire logic debug_data_en,
  input wire logic debug_data_val,
  input wire logic prog_clock_en,
  input wire logic debug_clock_en,
  input wire logic serial_rx_data_en,
  input wire logic serial_rx_data_val,
  input wire logic sr_latch_out_en,
  input wire logic sr_latch_out_val,
  input wire logic clock_output_en,
  input wire logic clock_output_val,
  input wire logic pwm1_c_out_en,
  input wire logic ccp_two_primary_out_en,
  input wire logic [3:0] portc_ovr_en,
  input wire logic ccp_two_dflt_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_oe_pin_three: assert property (pin_oe[3] == 1'b0)
    else $error("pin 3 output enabled");
  a_pullup_on_output: assert property ((pin_pullup_on & pin_oe) == 6'h00)
    else $error("pull-up on a driven pin");
  a_analog_reads_zero: assert property ((pin_din & pin_analog_en) == 6'h00)
    else $error("analog pin reads one");
  a_pin0_first: assert property (prog_data_en |=> pin_o[0] == $past(prog_data_val))
    else $error("pin 0 first source lost");
  a_pin0_second: assert property (!prog_data_en && debug_data_en |=>
    pin_o[0] == $past(debug_data_val)) else $error("pin 0 second source lost");
  a_pin1_third: assert property (!prog_clock_en && !debug_clock_en && serial_rx_data_en
    |=> pin_o[1] == $past(serial_rx_data_val)) else $error("pin 1 third source lost");
  a_pin2_first: assert property (sr_latch_out_en |=> pin_o[2] == $past(sr_latch_out_val))
    else $error("pin 2 first source lost");
  a_pin4_first: assert property (clock_output_en |=> pin_o[4] == $past(clock_output_val))
    else $error("pin 4 first source lost");
  a_ccp_dflt_cause: assert property (ccp_two_dflt_en |-> $past(ccp_two_primary_out_en))
    else $error("default pin driven without source");
  a_portc_cause: assert property (portc_ovr_en[1] |-> $past(pwm1_c_out_en))
    else $error("port C pin 1 driven without source");
  a_bvalid_pulse: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after handshake");
  a_reset_quiet: assert property (disable iff (1'b0) !nrst |-> ##1
    (pin_oe == 6'h00 && pin_pullup_on == 6'h00 && !s_axi_bvalid))
    else $error("outputs active after reset");
endmodule

bind pax_port pax_port_checker i_pax_port_checker (
  .core_clk, .nrst, .s_axi_bvalid, .s_axi_bready, .pin_o, .pin_oe, .pin_pullup_on,
  .pin_analog_en, .pin_din, .prog_data_en, .prog_data_val, .debug_data_en, .debug_data_val,
  .prog_clock_en, .debug_clock_en, .serial_rx_data_en, .serial_rx_data_val,
  .sr_latch_out_en, .sr_latch_out_val, .clock_output_en, .clock_output_val,
  .pwm1_c_out_en, .ccp_two_primary_out_en, .portc_ovr_en, .ccp_two_dflt_en
);

// [test/pax_pin_board.sv]
// Board-side pin load: external drivers, mid-level inputs and pull-ups
`timescale 1ns/1ps
module pax_pin_board (
  input wire logic core_clk,
  input wire logic [5:0] pin_o,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] pin_pullup_on,
  input wire logic [5:0] ext_en,
  input wire logic [5:0] ext_val,
  input wire logic [5:0] ext_mid,
  output logic [5:0] pin_st_i,
  output logic [5:0] pin_ttl_i
);
  logic [5:0] float_r = 6'h00;
  logic [5:0] lvl;
  // Undriven pin wanders: inverse of its last level
  always_ff @(posedge core_clk) begin
    float_r <= ~lvl;
  end
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pin_oe[i]) lvl[i] = pin_o[i];
      else if (ext_en[i]) lvl[i] = ext_val[i];
      else if (pin_pullup_on[i]) lvl[i] = 1'b1;
      else lvl[i] = float_r[i];
    end
  end
  // Mid-level: below Schmitt high, above TTL high
  assign pin_st_i = lvl & ~ext_mid;
  assign pin_ttl_i = lvl | ext_mid;
endmodule

// [test/test_pax_port.sv]
// Self-checking bench for the port A block
`timescale 1ns/1ps
module test_pax_port
  import pax_pkg::*;
;
  localparam logic [63:0] RST_TAB = 64'h0080000017003f00;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00;
  logic [5:0] s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
  logic [31:0] s_axi_rdata, rd_data;
  logic [5:0] pin_st_i, pin_ttl_i, pin_o, pin_oe, pin_pullup_on, pin_analog_en, pin_din;
  logic [5:0] ext_en = 6'h3f;
  logic [5:0] ext_val = 6'h00;
  logic [5:0] ext_mid = 6'h00;
  logic [16:0] src_en = 17'h0;
  logic [16:0] src_val = 17'h0;
  logic [1:0] p5_en = 2'h0;
  logic [1:0] p5_val = 2'h0;
  logic [3:0] portc_ovr_en, portc_ovr_val;
  logic ccp_two_dflt_en, ccp_two_dflt_val;
  int n_mismatch = 0;
  int cmp_count = 0;

  pax_port i_pax_port (
    .core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pin_st_i, .pin_ttl_i, .pin_o, .pin_oe, .pin_pullup_on,
    .pin_analog_en, .pin_din,
    .prog_data_en(src_en[0]), .prog_data_val(src_val[0]),
    .debug_data_en(src_en[1]), .debug_data_val(src_val[1]),
    .dac_output_en(src_en[2]), .dac_output_val(src_val[2]),
    .prog_clock_en(src_en[3]), .prog_clock_val(src_val[3]),
    .debug_clock_en(src_en[4]), .debug_clock_val(src_val[4]),
    .serial_rx_data_en(src_en[5]), .serial_rx_data_val(src_val[5]),
    .sr_latch_out_en(src_en[6]), .sr_latch_out_val(src_val[6]),
    .comparator_one_out_en(src_en[7]), .comparator_one_out_val(src_val[7]),
    .capture_compare_three_en(src_en[8]), .capture_compare_three_val(src_val[8]),
    .clock_output_en(src_en[9]), .clock_output_val(src_val[9]),
    .timer_one_osc_out_en(src_en[10]), .timer_one_osc_out_val(src_val[10]),
    .reference_clock_out_en(src_en[11]), .reference_clock_out_val(src_val[11]),
    .spi_sdo_en(src_en[12]), .spi_sdo_val(src_val[12]),
    .pwm2_b_out_en(src_en[13]), .pwm2_b_out_val(src_val[13]),
    .pwm1_d_out_en(src_en[14]), .pwm1_d_out_val(src_val[14]),
    .pwm1_c_out_en(src_en[15]), .pwm1_c_out_val(src_val[15]),
    .ccp_two_primary_out_en(src_en[16]), .ccp_two_primary_out_val(src_val[16]),
    .pin5_src_en(p5_en), .pin5_src_val(p5_val), .portc_ovr_en, .portc_ovr_val,
    .ccp_two_dflt_en, .ccp_two_dflt_val
  );
  pax_pin_board i_pax_pin_board (
    .core_clk, .pin_o, .pin_oe, .pin_pullup_on, .ext_en, .ext_val, .ext_mid,
    .pin_st_i, .pin_ttl_i
  );

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, want %h", $time, g, e);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic axi_wr(input logic [5:0] a, input logic [7:0] d, input logic [3:0] s);
    int t;
    @(posedge core_clk);
    t = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      t++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && t < 50);
    s_axi_bready <= 1'b0;
    if (t >= 50) n_mismatch++;
    chk(s_axi_bresp, a > PAX_OFS_ALT_PIN_SEL1 ? PAX_RESP_SLVERR : PAX_RESP_OKAY);
  endtask
  task automatic axi_rd(input logic [5:0] a);
    int t;
    @(posedge core_clk);
    t = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      t++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && t < 50);
    s_axi_rready <= 1'b0;
    if (t >= 50) n_mismatch++;
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    axi_rd(a);
    chk(rd_resp, PAX_RESP_OKAY);
    chk(rd_data, {24'h0, e});
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    int pn, bs, cn;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    settle(2);
    for (int i = 0; i < 8; i++)
      rd_chk(6'(i * 4), RST_TAB[i * 8 +: 8]);
    axi_wr(PAX_OFS_ALT_PIN_SEL1, 8'hff, 4'h1);
    rd_chk(PAX_OFS_ALT_PIN_SEL1, 8'h0f);
    axi_rd(6'h20);
    chk(rd_resp, PAX_RESP_SLVERR);
    chk(rd_data, 32'h0);
    axi_wr(6'h20, 8'hff, 4'h1);
    // Directions, latch and analog masking of reads
    axi_wr(PAX_OFS_DIR_BITS, 8'h00, 4'h1);
    rd_chk(PAX_OFS_DIR_BITS, 8'h08);
    axi_wr(PAX_OFS_OUT_LATCH, 8'h3f, 4'h1);
    rd_chk(PAX_OFS_OUT_LATCH, 8'h37);
    axi_wr(PAX_OFS_PORT_DATA, 8'h25, 4'h1);
    settle(4);
    chk(pin_o & 6'h37, 6'h25);
    chk(pin_oe, 6'h37);
    chk(pin_din, 6'h20);
    chk(pin_analog_en, 6'h17);
    rd_chk(PAX_OFS_PORT_DATA, 8'h20);
    axi_wr(PAX_OFS_ANALOG_SEL, 8'h00, 4'h1);
    settle(4);
    rd_chk(PAX_OFS_PORT_DATA, 8'h25);
    // Port write merges sampled pin levels, not the old latch
    axi_wr(PAX_OFS_DIR_BITS, 8'h3f, 4'h1);
    ext_val <= 6'h2b;
    settle(4);
    rd_chk(PAX_OFS_PORT_DATA, 8'h2b);
    axi_wr(PAX_OFS_PORT_DATA, 8'h00, 4'h0);
    rd_chk(PAX_OFS_OUT_LATCH, 8'h23);
    // Threshold change made with every peripheral source idle
    ext_val <= 6'h00;
    ext_mid <= 6'h01;
    settle(4);
    rd_chk(PAX_OFS_PORT_DATA, 8'h00);
    axi_wr(PAX_OFS_THRESH_SEL, 8'h01, 4'h1);
    settle(4);
    rd_chk(PAX_OFS_PORT_DATA, 8'h01);
    chk(pin_din, 6'h01);
    ext_mid <= 6'h00;
    // Weak pull-ups
    axi_wr(PAX_OFS_OPTION, 8'h00, 4'h1);
    axi_wr(PAX_OFS_PULLUP_EN, 8'h3f, 4'h1);
    ext_en <= 6'h00;
    settle(2);
    chk(pin_pullup_on, 6'h3f);
    axi_wr(PAX_OFS_DIR_BITS, 8'h30, 4'h1);
    settle(2);
    chk(pin_pullup_on, 6'h38);
    axi_wr(PAX_OFS_OPTION, 8'h80, 4'h1);
    settle(2);
    chk(pin_pullup_on, 6'h00);
    // Output priorities, analog mode on
    axi_wr(PAX_OFS_ANALOG_SEL, 8'h17, 4'h1);
    axi_wr(PAX_OFS_ALT_PIN_SEL1, 8'h02, 4'h1);
    axi_wr(PAX_OFS_OUT_LATCH, 8'h3f, 4'h1);
    for (int g = 0; g < 4; g++) begin
      pn = (g == 3) ? 4 : g;
      bs = 3 * g;
      cn = (g == 3) ? 5 : 3;
      src_val <= g[0] ? 17'h0aaaa : 17'h15555;
      for (int k = 0; k < cn; k++) begin
        src_en <= 17'(((1 << cn) - (1 << k)) << bs);
        settle(2);
        chk(pin_o[pn], src_val[bs + k]);
      end
    end
    // Alternate pin routing
    src_en <= 17'h1e000;
    src_val <= 17'h14000;
    axi_wr(PAX_OFS_OUT_LATCH, 8'h10, 4'h1);
    axi_wr(PAX_OFS_ALT_PIN_SEL1, 8'h00, 4'h1);
    settle(2);
    chk({portc_ovr_en, portc_ovr_val[3:2]}, 6'b1100_01);
    chk({ccp_two_dflt_en, ccp_two_dflt_val, pin_o[5]}, 3'b110);
    axi_wr(PAX_OFS_ALT_PIN_SEL1, 8'h0f, 4'h1);
    settle(2);
    chk({portc_ovr_en, portc_ovr_val[1:0]}, 6'b0011_01);
    chk({ccp_two_dflt_en, pin_o[5:4]}, 3'b0_10);
    p5_en <= 2'b11;
    p5_val <= 2'b10;
    settle(2);
    chk(pin_o[5], 1'b0);
    // Second reset in mid-run
    nrst <= 1'b0;
    settle(2);
    nrst <= 1'b1;
    settle(2);
    rd_chk(PAX_OFS_ALT_PIN_SEL1, 8'h00);
    print_verdict();
  end
endmodule
